/* File: src/fp_operand_format_classifier.sv */
// Operand-format front end of the floating-point slave processor.
// Assumes the host protocol has already gathered operands into a request
// and that one request arrives per cycle at most; answer one cycle later.
`timescale 1ns/10ps
module fp_operand_format_classifier (
   // Clock and reset
   input  logic                    clk_sys,
   input  logic                    sys_rst,
   // Operation request
   input  fp_operand_pkg::req_type req,
   // Operation answer
   output fp_operand_pkg::rsp_type rsp
);

   // ==========================================================
   // Operand decoders
   fp_operand_pkg::dec_type da;   // First operand fields
   fp_operand_pkg::dec_type db;   // Second operand fields

   // Both share the request precision
   fp_operand_decode u_dec_a (
      .prec (req.prec),
      .word (req.a),
      .dec  (da)
   );
   fp_operand_decode u_dec_b (
      .prec (req.prec),
      .word (req.b),
      .dec  (db)
   );

   // ==========================================================
   // Narrowing to single with rounding
   // Packs {overflow, underflow, inexact, single word}
   function automatic logic [34:0] narrow(
      input logic                    s,
      input logic [11:0]             e,
      input logic [51:0]             f,
      input fp_operand_pkg::rnd_type r
   );
      logic [12:0] eb;    // Rebiased exponent
      logic [30:0] mag;   // Exponent and fraction
      logic        inx;   // Bits lost
      logic        up;    // Round magnitude up
      logic        ovf;   // Too large
      eb  = 13'({e[11], e}) + 13'(fp_operand_pkg::SGL_BIAS);
      inx = |f[28:0];
      up  = 1'b0;
      ovf = 1'b0;
      mag = '0;
      if ($signed(eb) <= 13'sh0) begin
         // Underflow yields positive zero, flagged only
         return {1'b0, 1'b1, 1'b1, 32'h0};
      end
      if ($signed(eb) >= 13'(fp_operand_pkg::SGL_EXP_MAX)) begin
         ovf = 1'b1;
      end
      unique case (r)
         fp_operand_pkg::RND_NEAR:  up = f[28] & ((|f[27:0]) | f[29]);
         fp_operand_pkg::RND_ZERO:  up = 1'b0;
         fp_operand_pkg::RND_FLOOR: up = s & inx;
         default:                   up = 1'b0;
      endcase
      mag = {eb[7:0], f[51:29]} + 31'(up);
      // Carry out of the fraction may reach all-ones exponent
      ovf = ovf | (&mag[30:23]);
      return {ovf, 1'b0, inx, s, mag};
   endfunction : narrow

   // ==========================================================
   // Precision conversion paths
   logic [34:0] nar_conv;   // Double narrowed to single
   logic [63:0] wide_conv;  // Single widened to double

   always_comb begin
      nar_conv  = narrow(da.sign, da.exp, da.frac, req.rnd);
      // Widening is exact: rebias, keep left-aligned fraction
      wide_conv = {da.sign,
                   11'(da.exp + 12'(fp_operand_pkg::DBL_BIAS)),
                   da.frac};
      if (da.zero) begin
         // Keep the sign of a zero
         wide_conv = {da.sign, 63'h0};
         nar_conv  = {3'h0, da.sign, 31'h0};
      end
   end

   // ==========================================================
   // Integer to float
   logic [31:0] iv;        // Sign-extended integer
   logic [31:0] imag;      // Integer magnitude
   logic [5:0]  ipos;      // Leading one position
   logic [52:0] isig;      // Aligned significand
   logic [63:0] flt_dbl;   // Double result
   logic [34:0] flt_sgl;   // Single result with flags

   always_comb begin
      // Accept byte, word or double word
      unique case (req.isize)
         fp_operand_pkg::INT_BYTE:
            iv = {{24{req.a[fp_operand_pkg::INT8_W-1]}}, req.a[7:0]};
         fp_operand_pkg::INT_WORD:
            iv = {{16{req.a[fp_operand_pkg::INT16_W-1]}}, req.a[15:0]};
         default:
            iv = req.a[fp_operand_pkg::INT32_W-1:0];
      endcase
      // Magnitude as unsigned also covers the most negative value
      imag = iv[31] ? 32'(-iv) : iv;
      ipos = 6'h0;
      for (int i = 0; i < 32; i++) begin
         if (imag[i]) begin
            ipos = 6'(i);
         end
      end
      isig    = 53'(imag) << (6'd52 - ipos);
      flt_dbl = {iv[31],
                 11'(12'(ipos) + 12'(fp_operand_pkg::DBL_BIAS)),
                 isig[51:0]};
      flt_sgl = narrow(iv[31], 12'(ipos), isig[51:0], req.rnd);
      if (imag == 32'h0) begin
         flt_dbl = 64'h0;
         flt_sgl = 35'h0;
      end
   end

   // ==========================================================
   // Float to integer with rounding
   logic [84:0] fx;     // Value scaled by two to the 32
   logic [31:0] ip;     // Integer part
   logic        half;   // Half bit
   logic        stk;    // Bits below half
   logic        rup;    // Round magnitude up
   logic [32:0] rmag;   // Rounded magnitude
   logic [32:0] rlim;   // Largest legal magnitude
   logic [31:0] rval;   // Signed result
   logic        rovf;   // Out of destination range
   logic        rinx;   // Result inexact

   always_comb begin
      fx   = '0;
      ip   = 32'h0;
      half = 1'b0;
      stk  = 1'b0;
      rovf = 1'b0;
      if ($signed(da.exp) > 12'sd31 && !da.zero) begin
         rovf = 1'b1;
      end else if ($signed(da.exp) < -12'sd1 && !da.zero) begin
         // Below one half: only the sticky survives
         stk = 1'b1;
      end else if (!da.zero) begin
         fx   = {da.sig, 32'h0} >> 6'(12'd52 - da.exp);
         ip   = fx[63:32];
         half = fx[31];
         stk  = |fx[30:0];
      end
      rinx = half | stk;
      // Three rounding methods
      unique case (req.rnd)
         fp_operand_pkg::RND_NEAR:  rup = half & (stk | ip[0]);
         fp_operand_pkg::RND_ZERO:  rup = 1'b0;
         fp_operand_pkg::RND_FLOOR: rup = da.sign & rinx;
         default:                   rup = 1'b0;
      endcase
      rmag = 33'(ip) + 33'(rup);
      // Negative side reaches one further
      unique case (req.isize)
         fp_operand_pkg::INT_BYTE:  rlim = 33'h7f;
         fp_operand_pkg::INT_WORD:  rlim = 33'h7fff;
         default:                   rlim = 33'h7fffffff;
      endcase
      rlim = rlim + 33'(da.sign);
      rovf = rovf | (rmag > rlim);
      rval = da.sign ? 32'(-rmag) : rmag[31:0];
   end

   // ==========================================================
   // Compare on sign-magnitude words
   logic [62:0] ma;    // Magnitude bits of a
   logic [62:0] mb;    // Magnitude bits of b
   logic        c_eq;  // Equal
   logic        c_lt;  // a below b

   always_comb begin
      ma = (req.prec == fp_operand_pkg::PREC_L) ?
           req.a[62:0] : {32'h0, req.a[30:0]};
      mb = (req.prec == fp_operand_pkg::PREC_L) ?
           req.b[62:0] : {32'h0, req.b[30:0]};
      if (da.zero && db.zero) begin
         // Signed zeros compare equal
         c_eq = 1'b1;
         c_lt = 1'b0;
      end else if (da.sign != db.sign) begin
         // Sign 1 is the negative side
         c_eq = 1'b0;
         c_lt = da.sign;
      end else begin
         c_eq = (ma == mb);
         c_lt = da.sign ? (ma > mb) : (ma < mb);
      end
   end

   // ==========================================================
   // Answer next state
   fp_operand_pkg::rsp_type rsp_d;   // Next answer
   fp_operand_pkg::rsp_type rsp_q;   // Registered answer
   logic                    two_op;  // Second operand is a float
   logic                    rsv_in;  // Any reserved float input
   logic                    dbl;     // Double precision request

   always_comb begin
      rsp_d       = '0;
      dbl         = (req.prec == fp_operand_pkg::PREC_L);
      two_op      = req.op inside {fp_operand_pkg::OP_CMP,
                                   fp_operand_pkg::OP_ADD,
                                   fp_operand_pkg::OP_SUB,
                                   fp_operand_pkg::OP_MUL,
                                   fp_operand_pkg::OP_DIV};
      rsv_in      = da.rsv | (two_op & db.rsv);
      rsp_d.done  = req.valid;
      rsp_d.dec_a = da;
      rsp_d.dec_b = db;
      if (req.valid) begin
         unique case (req.op)
            fp_operand_pkg::OP_MOV: begin
               // Plain copy, no format change
               rsp_d.data = dbl ? req.a : {32'h0, req.a[31:0]};
            end
            fp_operand_pkg::OP_NEG: begin
               // Only the sign flips
               rsp_d.data = dbl ? req.a : {32'h0, req.a[31:0]};
               if (dbl) begin
                  rsp_d.data[fp_operand_pkg::DBL_SIGN_POS] = ~da.sign;
               end else begin
                  rsp_d.data[fp_operand_pkg::SGL_SIGN_POS] = ~da.sign;
               end
            end
            fp_operand_pkg::OP_CMP: begin
               rsp_d.eq = c_eq;
               rsp_d.lt = c_lt;
            end
            fp_operand_pkg::OP_ADD,
            fp_operand_pkg::OP_SUB,
            fp_operand_pkg::OP_MUL: begin
               // Screened operands go to the arithmetic unit
               rsp_d.arith_go = 1'b1;
            end
            fp_operand_pkg::OP_DIV: begin
               rsp_d.arith_go = 1'b1;
               if (da.zero && db.zero) begin
                  // Zero over zero is invalid
                  rsp_d.trap     = 1'b1;
                  rsp_d.tt       = fp_operand_pkg::TT_INVALID;
                  rsp_d.arith_go = 1'b0;
               end else if (db.zero) begin
                  rsp_d.trap     = 1'b1;
                  rsp_d.tt       = fp_operand_pkg::TT_DIVZ;
                  rsp_d.arith_go = 1'b0;
               end
            end
            fp_operand_pkg::OP_CONV: begin
               // Source precision is the request's
               if (dbl) begin
                  rsp_d.data = {32'h0, nar_conv[31:0]};
                  if (nar_conv[34]) begin
                     rsp_d.trap = 1'b1;
                     rsp_d.tt   = fp_operand_pkg::TT_OVER;
                  end else if (nar_conv[33]) begin
                     rsp_d.tt   = fp_operand_pkg::TT_UNDER;
                  end else if (nar_conv[32]) begin
                     rsp_d.tt   = fp_operand_pkg::TT_INEXACT;
                  end
               end else begin
                  rsp_d.data = wide_conv;
               end
            end
            fp_operand_pkg::OP_FLT: begin
               // Integer in, float of request precision out
               rsp_d.data = dbl ? flt_dbl : {32'h0, flt_sgl[31:0]};
               if (!dbl && flt_sgl[32]) begin
                  rsp_d.tt = fp_operand_pkg::TT_INEXACT;
               end
            end
            fp_operand_pkg::OP_RND: begin
               rsp_d.data = {32'h0, rval};
               if (rovf) begin
                  rsp_d.trap = 1'b1;
                  rsp_d.tt   = fp_operand_pkg::TT_OVER;
               end else if (rinx) begin
                  rsp_d.tt   = fp_operand_pkg::TT_INEXACT;
               end
            end
            default: begin
               rsp_d.trap = 1'b1;
            end
         endcase
         // Reserved input: software handles it
         if (rsv_in && req.op != fp_operand_pkg::OP_MOV &&
             req.op != fp_operand_pkg::OP_FLT) begin
            rsp_d.trap     = 1'b1;
            rsp_d.tt       = fp_operand_pkg::TT_INVALID;
            rsp_d.arith_go = 1'b0;
            rsp_d.eq       = 1'b0;
            rsp_d.lt       = 1'b0;
         end
         // No result word leaves with a trap
         if (rsp_d.trap) begin
            rsp_d.data = 64'h0;
         end
      end
   end

   // ==========================================================
   // Answer register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   assign rsp = rsp_q;

   // ==========================================================
   // Checks
   fp_operand_pkg::op_type op_q;   // Operation of last request
   logic                   dbl_q;  // Its precision

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         op_q  <= fp_operand_pkg::OP_MOV;
         dbl_q <= 1'b0;
      end else begin
         op_q  <= req.op;
         dbl_q <= dbl;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   mov_no_trap_a: assert property (
      req.valid && req.op == fp_operand_pkg::OP_MOV && dbl
      |=> !rsp_q.trap && rsp_q.data == $past(req.a))
      else $error("move trapped or altered operand");
   rsv_invalid_a: assert property (
      req.valid && da.rsv && req.op == fp_operand_pkg::OP_NEG
      |=> rsp_q.done && rsp_q.trap && rsp_q.tt == 3'h5)
      else $error("reserved operand not reported invalid");
   neg_sign_a: assert property (
      req.valid && req.op == fp_operand_pkg::OP_NEG && dbl && !da.rsv
      |=> rsp_q.data == ($past(req.a) ^ 64'h8000000000000000))
      else $error("negate changed more than the sign");
   zero_class_a: assert property (
      (req.a[62:0] == 63'h0 && dbl) |-> da.zero && !da.rsv && !da.norm)
      else $error("zero word not decoded as zero");
   single_bias_a: assert property (
      da.norm && !dbl
      |-> da.exp == 12'({1'b0, da.efld}) - 12'd127)
      else $error("single exponent bias wrong");
   hidden_bit_a: assert property (
      da.norm |-> da.sig[52] && da.sig[51:0] == da.frac)
      else $error("hidden bit missing");
   narrow_out_a: assert property (
      rsp_q.done && !rsp_q.trap && op_q == fp_operand_pkg::OP_CONV
      && dbl_q |-> !(&rsp_q.data[30:23]))
      else $error("narrowing delivered reserved exponent");
   zero_div_a: assert property (
      req.valid && req.op == fp_operand_pkg::OP_DIV
      && da.zero && db.zero
      |=> rsp_q.trap && rsp_q.tt == fp_operand_pkg::TT_INVALID)
      else $error("zero over zero not invalid");
   done_one_a: assert property (
      req.valid |=> rsp_q.done)
      else $error("answer strobe missing");

   cov_rsv_c: cover property (req.valid && da.rsv ##1 rsp_q.trap);
   cov_narrow_c: cover property (
      req.valid && req.op == fp_operand_pkg::OP_CONV && dbl);
   cov_round_c: cover property (
      req.valid && req.op == fp_operand_pkg::OP_RND && rinx);

endmodule : fp_operand_format_classifier

/* File: src/fp_operand_pkg.sv */
// Shared constants and carriers for the floating-point operand front end.
// Assumes a single 25 MHz system clock and one request per cycle at most.
package fp_operand_pkg;

   // ==========================================================
   // Word formats
   localparam int SGL_W        = 32;   // Single word width
   localparam int DBL_W        = 64;   // Double word width
   localparam int SGL_EXP_W    = 8;    // Single exponent field
   localparam int DBL_EXP_W    = 11;   // Double exponent field
   localparam int SGL_FRAC_W   = 23;   // Single fraction field
   localparam int DBL_FRAC_W   = 52;   // Double fraction field
   localparam int SGL_SIGN_POS = 31;   // Single sign bit
   localparam int DBL_SIGN_POS = 63;   // Double sign bit
   localparam int SGL_EXP_LSB  = 23;   // Single exponent low bit
   localparam int DBL_EXP_LSB  = 52;   // Double exponent low bit
   localparam int SGL_BIAS     = 127;  // Single exponent bias
   localparam int DBL_BIAS     = 1023; // Double exponent bias
   localparam int SGL_EXP_MAX  = 255;  // All-ones single exponent

   // ==========================================================
   // Integer widths
   localparam int INT8_W  = 8;
   localparam int INT16_W = 16;
   localparam int INT32_W = 32;

   // ==========================================================
   // Trap type codes
   localparam logic [2:0] TT_NONE    = 3'h0;
   localparam logic [2:0] TT_UNDER   = 3'h1;
   localparam logic [2:0] TT_OVER    = 3'h2;
   localparam logic [2:0] TT_DIVZ    = 3'h3;
   localparam logic [2:0] TT_INVALID = 3'h5;
   localparam logic [2:0] TT_INEXACT = 3'h6;

   // ==========================================================
   // Enumerations
   typedef enum logic [3:0] {
      OP_MOV, OP_NEG, OP_CMP, OP_ADD, OP_SUB,
      OP_MUL, OP_DIV, OP_CONV, OP_FLT, OP_RND
   } op_type;
   typedef enum logic {PREC_F, PREC_L} prec_type;
   typedef enum logic [1:0] {INT_BYTE, INT_WORD, INT_DWORD} int_size_type;
   typedef enum logic [1:0] {RND_NEAR, RND_ZERO, RND_FLOOR} rnd_type;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic         valid;     // Request present this cycle
      op_type       op;        // Operation
      prec_type     prec;      // Float precision (suffix)
      int_size_type isize;     // Integer operand width
      rnd_type      rnd;       // Rounding method
      logic [63:0]  a;         // First operand (single in low word)
      logic [63:0]  b;         // Second operand
   } req_type;

   typedef struct packed {
      logic         sign;      // Sign bit
      logic [10:0]  efld;      // Raw exponent field
      logic [11:0]  exp;       // Unbiased exponent, two's complement
      logic [51:0]  frac;      // Fraction, left aligned
      logic [52:0]  sig;       // Significand with hidden bit
      logic         zero;      // Either zero
      logic         norm;      // Normalized
      logic         denorm;    // Denormalized
      logic         inf_nan;   // Infinity or NaN
      logic         rsv;       // Reserved operand
   } dec_type;

   typedef struct packed {
      logic         done;      // Answer strobe
      logic         trap;      // Operation trapped
      logic [2:0]   tt;        // Trap type code
      logic [63:0]  data;      // Result word
      logic         eq;        // Compare: equal
      logic         lt;        // Compare: a below b
      logic         arith_go;  // Hand operands to arithmetic unit
      dec_type      dec_a;     // Decoded first operand
      dec_type      dec_b;     // Decoded second operand
   } rsp_type;

endpackage : fp_operand_pkg

/* File: src/fp_operand_decode.sv */
// Field splitter and classifier for one floating-point operand.
// Assumes a single-precision word sits in the low 32 bits.
`timescale 1ns/10ps
module fp_operand_decode (
   // Format select
   input  fp_operand_pkg::prec_type prec,
   // Raw operand word
   input  logic [63:0]              word,
   // Decoded fields and class
   output fp_operand_pkg::dec_type  dec
);

   // ==========================================================
   // Field extraction and classification
   logic        efz;   // Exponent all zeroes
   logic        frz;   // Fraction all zeroes
   logic        ones;  // Exponent all ones
   logic [11:0] bias;  // Bias of this format

   always_comb begin
      dec  = '0;
      ones = 1'b0;
      bias = 12'(fp_operand_pkg::SGL_BIAS);
      // Sign on top, exponent next, fraction low
      // Only two float widths exist, single or double
      if (prec == fp_operand_pkg::PREC_L) begin
         dec.sign = word[fp_operand_pkg::DBL_SIGN_POS];
         dec.efld = word[fp_operand_pkg::DBL_EXP_LSB +:
                         fp_operand_pkg::DBL_EXP_W];
         dec.frac = word[fp_operand_pkg::DBL_FRAC_W-1:0];
         ones     = &dec.efld;
         bias     = 12'(fp_operand_pkg::DBL_BIAS);
      end else begin
         // Single fraction is left aligned in the wide field
         dec.sign = word[fp_operand_pkg::SGL_SIGN_POS];
         dec.efld = 11'(word[fp_operand_pkg::SGL_EXP_LSB +:
                             fp_operand_pkg::SGL_EXP_W]);
         dec.frac = {word[fp_operand_pkg::SGL_FRAC_W-1:0], 29'h0};
         ones     = &dec.efld[fp_operand_pkg::SGL_EXP_W-1:0];
      end
      efz         = (dec.efld == 11'h0);
      frz         = (dec.frac == 52'h0);
      dec.zero    = efz & frz;
      dec.denorm  = efz & ~frz;
      dec.inf_nan = ones;
      dec.rsv     = dec.denorm | dec.inf_nan;
      dec.norm    = ~efz & ~ones;
      // True exponent is field minus bias
      dec.exp     = 12'({1'b0, dec.efld}) - bias;
      // Hidden leading one ahead of the fraction
      dec.sig     = {dec.norm, dec.frac};
   end

endmodule : fp_operand_decode

/* File: test/fp_host_model.sv */
// Host side model: issues one request and captures the answer.
// Assumes the answer is registered on the edge that takes the request.
`timescale 1ns/10ps
module fp_host_model (
   // Clock
   input  logic                    clk_sys,
   // Request and answer
   output fp_operand_pkg::req_type req,
   input  fp_operand_pkg::rsp_type rsp
);
   // ==========================================================
   // Driver
   fp_operand_pkg::rsp_type got;  // Captured answer
   initial req = '0;
   // Operands are inverted once released, so stale values never pass
   task automatic issue(input fp_operand_pkg::op_type op,
      input fp_operand_pkg::prec_type pr,
      input fp_operand_pkg::int_size_type sz,
      input fp_operand_pkg::rnd_type rm, input logic [63:0] a, b);
      @(posedge clk_sys);
      req <= {1'b1, op, pr, sz, rm, a, b};
      @(posedge clk_sys);
      req <= {1'b0, op, pr, sz, rm, ~a, ~b};
      #1 got = rsp;
   endtask : issue
endmodule : fp_host_model

/* File: test/fp_operand_format_classifier_tb.sv */
// Self-checking bench for the operand format front end.
// Assumes the host model and the design package are compiled first.
`timescale 1ns/10ps
module fp_operand_format_classifier_tb;
   // ==========================================================
   // Signals
   logic                         clk_sys;  // 25 MHz clock
   logic                         sys_rst;  // Sync reset
   fp_operand_pkg::req_type      req;      // Request
   fp_operand_pkg::rsp_type      rsp;      // Answer
   fp_operand_pkg::int_size_type sz_v;     // Integer width
   fp_operand_pkg::rnd_type      rm_v;     // Rounding
   int                           failures; // Mismatches
   int                           compares; // Comparisons
   int                           cycles;   // Timeout count
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   fp_operand_format_classifier i_dut (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .req(req), .rsp(rsp));
   fp_host_model i_host (.clk_sys(clk_sys), .req(req), .rsp(rsp));
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [63:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic go(input fp_operand_pkg::op_type op,
      input fp_operand_pkg::prec_type pr, input logic [63:0] a, b);
      i_host.issue(op, pr, sz_v, rm_v, a, b);
   endtask : go
   task automatic wrap_up();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   // ==========================================================
   // Scenarios
   task automatic t_neg();
      go(fp_operand_pkg::OP_NEG, fp_operand_pkg::PREC_L, 64'h4008000000000001, 0);
      check(i_host.got.data, 64'hc008000000000001);
      go(fp_operand_pkg::OP_NEG, fp_operand_pkg::PREC_F, 64'hbfc00000, 0);
      check(i_host.got.data, 64'h3fc00000);
   endtask : t_neg
   task automatic t_dec();
      go(fp_operand_pkg::OP_MOV, fp_operand_pkg::PREC_F, 64'h3f400000, 0);
      check(64'(i_host.got.dec_a.exp), 64'hfff);
      check(64'(i_host.got.dec_a.sig), 64'h18000000000000);
      go(fp_operand_pkg::OP_MOV, fp_operand_pkg::PREC_L, 64'h4008000000000000, 0);
      check(64'({i_host.got.dec_a.efld, i_host.got.dec_a.exp,
         i_host.got.dec_a.norm}), 64'h800003);
   endtask : t_dec
   task automatic t_rsv();
      logic [63:0] v[3];
      v = '{64'h7f800000, 64'h7ff8000000000000, 64'h1};
      for (int i = 0; i < 3; i++) begin
         go(fp_operand_pkg::OP_ADD, (i == 1) ? fp_operand_pkg::PREC_L :
            fp_operand_pkg::PREC_F, v[i], 0);
         check(64'({i_host.got.trap, i_host.got.tt, i_host.got.arith_go,
            i_host.got.dec_a.rsv, i_host.got.dec_a.norm}), 64'h6a);
         check(i_host.got.data, 64'h0);
         go(fp_operand_pkg::OP_MOV, (i == 1) ? fp_operand_pkg::PREC_L :
            fp_operand_pkg::PREC_F, v[i], 0);
         check(64'({i_host.got.trap, i_host.got.data}), v[i]);
      end
   endtask : t_rsv
   task automatic t_zero();
      go(fp_operand_pkg::OP_CMP, fp_operand_pkg::PREC_F, 64'h80000000, 0);
      check(64'({i_host.got.eq, i_host.got.dec_a.zero, i_host.got.dec_b.zero,
         i_host.got.dec_a.sign}), 64'hf);
      go(fp_operand_pkg::OP_DIV, fp_operand_pkg::PREC_L, 0, 0);
      check(64'({i_host.got.trap, i_host.got.tt}), 64'hd);
      go(fp_operand_pkg::OP_DIV, fp_operand_pkg::PREC_L, 64'h3ff0000000000000, 0);
      check(64'({i_host.got.trap, i_host.got.tt}), 64'hb);
   endtask : t_zero
   task automatic t_arith();
      go(fp_operand_pkg::OP_CMP, fp_operand_pkg::PREC_L, 64'h3ff0000000000000,
         64'h4000000000000000);
      check(64'({i_host.got.eq, i_host.got.lt}), 64'h1);
      go(fp_operand_pkg::OP_ADD, fp_operand_pkg::PREC_F, 64'h3f800000, 64'h3f800000);
      check(64'({i_host.got.trap, i_host.got.arith_go}), 64'h1);
      go(fp_operand_pkg::OP_CONV, fp_operand_pkg::PREC_F, 64'h3f800000, 0);
      check(i_host.got.data, 64'h3ff0000000000000);
      go(fp_operand_pkg::OP_CONV, fp_operand_pkg::PREC_L,
         64'h3ff8000000000000, 0);
      check({i_host.got.tt, i_host.got.data}, 64'h3fc00000);
      sz_v = fp_operand_pkg::INT_BYTE;
      go(fp_operand_pkg::OP_FLT, fp_operand_pkg::PREC_F, 64'hff, 0);
      check(i_host.got.data, 64'hbf800000);
      sz_v = fp_operand_pkg::INT_WORD;
      go(fp_operand_pkg::OP_FLT, fp_operand_pkg::PREC_F, 64'h8000, 0);
      check(i_host.got.data, 64'hc7000000);
   endtask : t_arith
   task automatic t_rnd();
      sz_v = fp_operand_pkg::INT_DWORD;
      go(fp_operand_pkg::OP_RND, fp_operand_pkg::PREC_F, 64'h40200000, 0);
      check(i_host.got.data, 64'h2);
      rm_v = fp_operand_pkg::RND_ZERO;
      go(fp_operand_pkg::OP_RND, fp_operand_pkg::PREC_F, 64'hbfc00000, 0);
      check(i_host.got.data, 64'hffffffff);
      rm_v = fp_operand_pkg::RND_FLOOR;
      go(fp_operand_pkg::OP_RND, fp_operand_pkg::PREC_F, 64'hbfc00000, 0);
      check(i_host.got.data, 64'hfffffffe);
   endtask : t_rnd
   // ==========================================================
   // Main sequence and hang guard
   initial begin
      sys_rst = 1'b1;
      sz_v = fp_operand_pkg::INT_DWORD;
      rm_v = fp_operand_pkg::RND_NEAR;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      #1 check(64'({rsp.done, rsp.trap, rsp.tt}), 64'h0);
      t_neg();
      t_dec();
      t_rsv();
      t_zero();
      t_arith();
      t_rnd();
      wrap_up();
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         wrap_up();
      end
   end
endmodule : fp_operand_format_classifier_tb
